// ### line_enc_pkg.sv
// Purpose: Shared constants and mode codes for the multi-scheme line encoder.
// Assumes: One 125 MHz core clock; data rate default of 1 MHz.
// Notes:   Half-bit codes need two ticks per bit, so timing is kept in half-bits.
package line_enc_pkg;

  // Line code selector, one value per supported scheme
  typedef enum logic [3:0] {
    M_NRZI_ONE,     // Transition on a one
    M_NRZI_ZERO,    // Transition on a zero
    M_MAN_THOMAS,   // Zero rises mid-bit
    M_MAN_IEEE,     // One rises mid-bit
    M_DIFF_MAN,     // Differential Manchester
    M_AMI,          // Plain alternate mark inversion
    M_AMI_B8ZS,     // Eight-zero substitution variant, encoded as plain AMI
    M_AMI_HDB3,     // Four-zero substitution variant
    M_PSEUDO,       // Pseudoternary
    M_MLT3,         // Three-level cycle
    M_CMI,          // Coded mark inversion
    M_BMARK,        // Biphase mark
    M_MILLER,       // Delay code
    M_MOD_MILLER    // Miller-squared
  } line_mode_t;

  // Clock and default data rate
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned DATA_RATE_HZ = 1_000_000;
  // Half-bit period in core cycles, rounded down
  localparam int unsigned HALF_CYC     = CLK_HZ / (2 * DATA_RATE_HZ);
  // Zero run length that triggers substitution
  localparam int unsigned RUN_ZEROS    = 4;
  // Depth of the skid buffer in front of the encoder
  localparam int unsigned BUF_DEPTH    = 2;
  // Reset values of the line state
  localparam logic        LVL_RST      = 1'b0;
  localparam logic        MARK_RST     = 1'b0;

endpackage

// ### bit_stream_if.sv
// Purpose: Valid/ready stream carrier between encoder and its buffer.
// Assumes: Single clock domain.
// Notes:   Data width is a parameter; the encoder uses one bit.
`timescale 1ns/100ps
interface bit_stream_if #(
  parameter int unsigned W = 1
);
  logic         valid;  // Word offered
  logic         ready;  // Word taken when both high
  logic [W-1:0] data;   // Payload

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### bit_skid_buffer.sv
// Purpose: Small FIFO so a stalled encoder loses no input word.
// Assumes: Same clock on both sides.
// Notes:   Fill-side ready is registered so it can drive a top port directly.
`timescale 1ns/100ps
module bit_skid_buffer #(
  parameter int unsigned W     = 1,
  parameter int unsigned DEPTH = line_enc_pkg::BUF_DEPTH
)(
  input  wire logic  i_core_clk,
  input  wire logic  i_rstn,
  bit_stream_if.snk  in_s,
  bit_stream_if.src  out_s
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];   // Storage
  logic [AW-1:0] wp_q;          // Write pointer
  logic [AW-1:0] rp_q;          // Read pointer
  logic [CW-1:0] cnt_q;         // Fill level
  logic [CW-1:0] cnt_d;         // Next fill level
  logic          ready_q;       // Registered not-full
  wire           push = in_s.valid & ready_q;
  wire           pop  = out_s.ready & (cnt_q != '0);

  // Pointer wrap shared by both ends
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign cnt_d       = cnt_q + CW'(push) - CW'(pop);
  assign in_s.ready  = ready_q;
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem[rp_q];

  // Storage write, no reset needed on data
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wp_q] <= in_s.data;
    end
  end

  // Pointers, level and ready
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      if (push) wp_q <= nxt(wp_q);
      if (pop) rp_q <= nxt(rp_q);
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != CW'(DEPTH));
    end
  end
endmodule // bit_skid_buffer

// ### multi_scheme_line_encoder.sv
// Purpose: Serial NRZ to selectable line code encoder, ternary output.
// Assumes: Same-clock source; mode and rate inputs held steady while running.
// Notes:   Three-bit lookahead in every mode; empty buffer sends zero bits.
`timescale 1ns/100ps
module multi_scheme_line_encoder #(
  parameter int unsigned RATE_W = 16
)(
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  input  wire logic [3:0]        i_mode,
  input  wire logic              i_auto_rate,
  input  wire logic [RATE_W-1:0] i_rate_half,
  input  wire logic              i_valid,
  input  wire logic              i_data,
  output logic                   o_ready,
  output logic                   o_pos,
  output logic                   o_neg,
  output logic                   o_bit_start
);
  typedef line_enc_pkg::line_mode_t mode_t;

  bit_stream_if #(.W(1)) in_s ();   // Source side of buffer
  bit_stream_if #(.W(1)) out_s ();  // Encoder side of buffer

  wire mode_t mode = mode_t'(i_mode);  // Active line code

  // Rate timing
  logic [RATE_W-1:0] cnt_q;     // Half-bit down counter
  logic [RATE_W-1:0] gap_q;     // Cycles since last accepted word
  logic [RATE_W-1:0] meas_q;    // Measured half-bit length
  logic [RATE_W-1:0] half_len;  // Half-bit length in use
  logic              h_q;       // High while in second half
  wire               tick = (cnt_q == '0);
  wire               bs   = tick & h_q;   // Bit start
  wire               mid  = tick & ~h_q;  // Bit midpoint
  wire               acc  = in_s.valid & in_s.ready;

  // Line state
  logic       lvl_q;    // Two-level line level
  logic       mark_q;   // Last pulse was positive
  logic [1:0] step_q;   // MLT-3 phase
  logic       par_q;    // Odd pulse count since last violation
  logic       prev_q;   // Previous bit sent
  logic       run_q;    // Odd ones since last zero
  logic [1:0] sec_q;    // Planned second-half output
  logic [3:0] d_q;      // Lookahead bits, [0] just sent, [1] goes next
  logic [3:0] v_q;      // Violation marks
  logic [3:0] bt_q;     // Balancing marks

  // Lookahead shift and zero-run substitution
  wire       in_bit = out_s.valid & out_s.data;  // Empty buffer sends zero
  wire [3:0] ss     = {in_bit, d_q[3:1]};
  wire [3:0] vs     = {1'b0, v_q[3:1]};
  wire [3:0] bsh    = {1'b0, bt_q[3:1]};
  wire       sub    = (mode == line_enc_pkg::M_AMI_HDB3) && (ss == '0)
                      && (vs == '0) && (bsh == '0);
  wire [3:0] vn     = sub ? {1'b1, vs[2:0]} : vs;
  wire [3:0] bn     = (sub && !par_q) ? {bsh[3:1], 1'b1} : bsh;
  wire       cur_b  = ss[0];
  wire       nxt_b  = ss[1];
  wire       tag_v  = vn[0];
  wire       tag_b  = bn[0];

  // Pulse of given polarity as {pos, neg}
  function automatic logic [1:0] pulse(input logic p);
    pulse = p ? 2'b10 : 2'b01;
  endfunction

  // Manual value, else default; auto value once measured
  assign half_len = (i_auto_rate && meas_q != '0) ? meas_q :
                    (i_rate_half != '0) ? i_rate_half :
                    RATE_W'(line_enc_pkg::HALF_CYC);

  assign in_s.valid  = i_valid;
  assign in_s.data   = i_data;
  assign o_ready     = in_s.ready;
  assign out_s.ready = bs;  // One word per bit time

  bit_skid_buffer #(
    .W     (1),
    .DEPTH (line_enc_pkg::BUF_DEPTH)
  ) u_buf (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .in_s       (in_s),
    .out_s      (out_s)
  );

  // Per-bit encoding table
  logic [1:0] f2;      // First-half output
  logic [1:0] s2;      // Second-half output
  logic       lvl_d;
  logic       mark_d;
  logic [1:0] step_d;
  logic       par_d;
  logic       fl;      // Miller level at bit start
  logic       midt;    // Miller mid-bit toggle
  always_comb begin
    f2     = 2'b00;
    s2     = 2'b00;
    lvl_d  = lvl_q;
    mark_d = mark_q;
    step_d = step_q;
    par_d  = par_q;
    fl     = (!cur_b && !prev_q) ? ~lvl_q : lvl_q;
    midt   = cur_b && !(mode == line_enc_pkg::M_MOD_MILLER && !nxt_b && run_q);
    case (mode)
      line_enc_pkg::M_NRZI_ONE: begin
        lvl_d = lvl_q ^ cur_b;
        f2    = {lvl_d, 1'b0};
        s2    = f2;
      end
      line_enc_pkg::M_NRZI_ZERO: begin
        lvl_d = lvl_q ^ ~cur_b;
        f2    = {lvl_d, 1'b0};
        s2    = f2;
      end
      line_enc_pkg::M_MAN_IEEE: begin
        f2    = {~cur_b, 1'b0};
        s2    = {cur_b, 1'b0};
        lvl_d = cur_b;
      end
      line_enc_pkg::M_MAN_THOMAS: begin
        f2    = {cur_b, 1'b0};
        s2    = {~cur_b, 1'b0};
        lvl_d = ~cur_b;
      end
      line_enc_pkg::M_DIFF_MAN: begin
        f2    = {cur_b ? lvl_q : ~lvl_q, 1'b0};
        lvl_d = ~f2[1];
        s2    = {lvl_d, 1'b0};
      end
      line_enc_pkg::M_AMI, line_enc_pkg::M_AMI_B8ZS: begin
        // Eight-zero substitution not supported; sent as plain marks
        if (cur_b) begin
          mark_d = ~mark_q;
          f2     = pulse(mark_d);
        end
        s2 = f2;
      end
      line_enc_pkg::M_AMI_HDB3: begin
        if (tag_v) begin
          f2    = pulse(mark_q);
          par_d = 1'b0;
        end else if (cur_b || tag_b) begin
          mark_d = ~mark_q;
          par_d  = ~par_q;
          f2     = pulse(mark_d);
        end
        s2 = f2;
      end
      line_enc_pkg::M_PSEUDO: begin
        if (!cur_b) begin
          mark_d = ~mark_q;
          f2     = pulse(mark_d);
        end
        s2 = f2;
      end
      line_enc_pkg::M_MLT3: begin
        step_d = step_q + {1'b0, cur_b};
        f2     = (step_d == 2'd1) ? 2'b10 : (step_d == 2'd3) ? 2'b01 : 2'b00;
        s2     = f2;
      end
      line_enc_pkg::M_CMI: begin
        if (cur_b) begin
          lvl_d = ~lvl_q;
          f2    = {lvl_d, 1'b0};
          s2    = f2;
        end else begin
          f2    = 2'b00;
          s2    = 2'b10;
          lvl_d = 1'b1;
        end
      end
      line_enc_pkg::M_BMARK: begin
        f2    = {~lvl_q, 1'b0};
        lvl_d = cur_b ? lvl_q : ~lvl_q;
        s2    = {lvl_d, 1'b0};
      end
      line_enc_pkg::M_MILLER, line_enc_pkg::M_MOD_MILLER: begin
        f2    = {fl, 1'b0};
        lvl_d = fl ^ midt;
        s2    = {lvl_d, 1'b0};
      end
      default: begin
        f2 = 2'b00;  // Unused codes idle at zero
        s2 = 2'b00;
      end
    endcase
  end

  // Half-bit timer and rate measurement
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q  <= '0;
      gap_q  <= '0;
      meas_q <= '0;
      h_q    <= 1'b1;
    end else begin
      cnt_q <= tick ? half_len - RATE_W'(1) : cnt_q - RATE_W'(1);
      if (tick) h_q <= ~h_q;
      if (acc) begin
        gap_q <= RATE_W'(1);
        if (gap_q >= RATE_W'(2)) meas_q <= gap_q >> 1;
      end else if (gap_q != '1) begin
        gap_q <= gap_q + RATE_W'(1);  // Saturates
      end
    end
  end

  // Line state and outputs
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_q       <= line_enc_pkg::LVL_RST;
      mark_q      <= line_enc_pkg::MARK_RST;
      step_q      <= '0;
      par_q       <= 1'b0;
      prev_q      <= 1'b1;
      run_q       <= 1'b0;
      sec_q       <= '0;
      d_q         <= '0;
      v_q         <= '0;
      bt_q        <= '0;
      o_pos       <= 1'b0;
      o_neg       <= 1'b0;
      o_bit_start <= 1'b0;
    end else begin
      o_bit_start <= bs;
      if (bs) begin
        {o_pos, o_neg} <= f2;
        sec_q  <= s2;
        lvl_q  <= lvl_d;
        mark_q <= mark_d;
        step_q <= step_d;
        par_q  <= par_d;
        prev_q <= cur_b;
        run_q  <= cur_b ? ~run_q : 1'b0;
        d_q    <= ss;
        v_q    <= vn;
        bt_q   <= bn;
      end else if (mid) begin
        {o_pos, o_neg} <= sec_q;
      end
    end
  end

  // Checks on encoded output
  sequence s_cmi_zero;
    bs && mode == line_enc_pkg::M_CMI && !cur_b;
  endsequence
  property p_nrzi;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && mode == line_enc_pkg::M_NRZI_ONE |=> (o_pos ^ $past(o_pos)) == $past(cur_b);
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi toggle wrong");
  property p_man;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && mode == line_enc_pkg::M_MAN_IEEE |=> o_pos == !$past(cur_b);
  endproperty
  a_man: assert property (p_man) else $error("manchester first half wrong");
  property p_ami;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && mode == line_enc_pkg::M_AMI && cur_b |=> o_pos == !$past(mark_q) && o_neg == $past(mark_q);
  endproperty
  a_ami: assert property (p_ami) else $error("ami polarity wrong");
  property p_hdb3_v;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && mode == line_enc_pkg::M_AMI_HDB3 && tag_v |=> o_pos == $past(mark_q) && o_neg != $past(mark_q);
  endproperty
  a_hdb3_v: assert property (p_hdb3_v) else $error("violation polarity wrong");
  property p_hdb3_b;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && sub |-> tag_b == !par_q ##1 v_q[3];
  endproperty
  a_hdb3_b: assert property (p_hdb3_b) else $error("balancing choice wrong");
  property p_mlt3;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && mode == line_enc_pkg::M_MLT3 && !cur_b |=> $stable(o_pos) && $stable(o_neg);
  endproperty
  a_mlt3: assert property (p_mlt3) else $error("mlt3 moved on zero");
  property p_pseudo;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && mode == line_enc_pkg::M_PSEUDO && cur_b |=> !o_pos && !o_neg;
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudoternary one not zero");
  property p_cmi_zero;
    @(posedge i_core_clk) disable iff (!i_rstn)
    s_cmi_zero |=> !o_pos;
  endproperty
  a_cmi_zero: assert property (p_cmi_zero) else $error("cmi zero first half high");
  property p_cmi_mid;
    @(posedge i_core_clk) disable iff (!i_rstn)
    mid && mode == line_enc_pkg::M_CMI && !prev_q |=> o_pos;
  endproperty
  a_cmi_mid: assert property (p_cmi_mid) else $error("cmi zero second half low");
  property p_bmark;
    @(posedge i_core_clk) disable iff (!i_rstn)
    bs && mode == line_enc_pkg::M_BMARK |=> o_pos != $past(o_pos);
  endproperty
  a_bmark: assert property (p_bmark) else $error("biphase start not toggled");
  property p_miller;
    @(posedge i_core_clk) disable iff (!i_rstn)
    mid && mode == line_enc_pkg::M_MILLER && prev_q |=> o_pos != $past(o_pos);
  endproperty
  a_miller: assert property (p_miller) else $error("miller one mid not toggled");
  property p_diff;
    @(posedge i_core_clk) disable iff (!i_rstn)
    mid && mode == line_enc_pkg::M_DIFF_MAN |=> o_pos != $past(o_pos);
  endproperty
  a_diff: assert property (p_diff) else $error("diff manchester mid not toggled");
endmodule // multi_scheme_line_encoder

// ### line_rx_model.sv
// Purpose: Line-side receiver model that captures both half-bit symbols of each bit.
// Assumes: Half-bit length fixed during a run and at least 2 cycles.
// Notes:   Keeps raw symbols only; the bench works out what they should be.
`timescale 1ns/100ps
module line_rx_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_pos,
  input  wire logic        i_neg,
  input  wire logic        i_bit_start,
  input  wire logic [15:0] i_half_len
);
  logic [3:0] rx_q[$];  // Symbols, first half in the upper pair
  logic [1:0] first_q;  // First-half levels held until mid-bit
  int         wait_q;   // Edges left to mid-bit, 0 when idle
  // First half on the bit-start cycle, second half one half-bit later
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_q.delete();
      wait_q = 0;
    end else begin
      // Mid-bit reached: the whole symbol is known
      if (wait_q == 1) rx_q.push_back({first_q, i_pos, i_neg});
      if (wait_q != 0) wait_q--;
      // New bit: its first half is on the line now
      if (i_bit_start) begin
        first_q = {i_pos, i_neg};
        wait_q  = int'(i_half_len);
      end
    end
  end
endmodule // line_rx_model

// ### testbench.sv
// Purpose: Self-checking bench for the line encoder, every mode.
// Assumes: Half-bit of 3 cycles in mode runs; leading idle zeros found by search.
// Notes:   Idle zeros after reset are part of the expected line, since they set state.
`timescale 1ns/100ps
module testbench;
  typedef bit         bits_t[$];   // Data bit stream
  typedef logic [3:0] sym_q_t[$];  // Symbol stream
  logic        clk = 1'h0;         // Core clock
  logic        i_rstn;             // Active-low reset
  logic [3:0]  i_mode;             // Line code select
  logic        i_auto_rate;        // Auto rate, on only in the auto-rate test
  logic [15:0] i_rate_half;        // Manual half-bit length
  logic        i_valid;            // Word offered
  logic        i_data;             // Word bit
  logic        o_ready, o_pos, o_neg, o_bit_start;
  int          err_total;          // Mismatches
  int          tests_run;          // Comparisons
  int          seed;               // Random seed
  int          hot;                // Cycles with a pulse on the line
  int          low_seen;           // Refusals while offering
  always #4 clk = ~clk;
  multi_scheme_line_encoder multi_scheme_line_encoder_i (
    .i_core_clk(clk), .i_rstn(i_rstn), .i_mode(i_mode), .i_auto_rate(i_auto_rate),
    .i_rate_half(i_rate_half), .i_valid(i_valid), .i_data(i_data), .o_ready(o_ready),
    .o_pos(o_pos), .o_neg(o_neg), .o_bit_start(o_bit_start));
  line_rx_model line_rx_model_i (
    .i_core_clk(clk), .i_rstn(i_rstn), .i_pos(o_pos), .i_neg(o_neg),
    .i_bit_start(o_bit_start), .i_half_len(i_rate_half));
  // Line activity and full-buffer refusals
  always @(posedge clk) begin
    if (o_pos === 1'h1 || o_neg === 1'h1) hot++;
    if (i_valid === 1'h1 && o_ready === 1'h0) low_seen++;
  end
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_sym(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle zeros, data, then trailing zeros that close open runs
  function automatic bits_t mk(input int z, input bits_t d);
    bits_t f;
    repeat (z) f.push_back(1'b0);
    f = {f, d};
    repeat (8) f.push_back(1'b0);
    return f;
  endfunction
  // Reference encoder from reset state: level 0, last mark negative, prior bit one
  function automatic sym_q_t enc(input int md, input bits_t b);
    sym_q_t e;
    logic   lv, m, pv, h1, h2, tw;
    logic [3:0] t;
    int     s, np, r, i;
    lv = 1'h0; m = 1'h0; pv = 1'h1; s = 0; np = 0; r = 0; i = 0;
    while (i < b.size()) begin
      // Four zeros: 000V on odd mark count, else B00V
      if (md == 7 && i + 3 < b.size() && !(b[i] | b[i+1] | b[i+2] | b[i+3])) begin
        if (np % 2 == 0) m = ~m;
        e = {e, (np % 2 == 0) ? (m ? 4'ha : 4'h5) : 4'h0, 4'h0, 4'h0, m ? 4'ha : 4'h5};
        np = 0;
        pv = 1'h0;
        i += 4;
        continue;
      end
      h1 = lv; h2 = lv; t = 4'h0; tw = 1'h1;
      case (md)
        0, 1: begin if (b[i] ^ (md == 1)) lv = ~lv; h1 = lv; h2 = lv; end
        2: begin h1 = b[i]; h2 = ~b[i]; end
        3: begin h1 = ~b[i]; h2 = b[i]; end
        4: begin if (!b[i]) lv = ~lv; h1 = lv; lv = ~lv; h2 = lv; end
        5, 6, 7: begin tw = 1'h0; if (b[i]) begin m = ~m; np++; t = m ? 4'ha : 4'h5; end end
        8: begin tw = 1'h0; if (!b[i]) begin m = ~m; t = m ? 4'ha : 4'h5; end end
        9: begin tw = 1'h0; if (b[i]) s = (s + 1) % 4; t = (s == 1) ? 4'ha : (s == 3) ? 4'h5 : 4'h0; end
        10: begin if (b[i]) begin lv = ~lv; h1 = lv; h2 = lv; end else begin h1 = 1'h0; h2 = 1'h1; lv = 1'h1; end end
        11: begin lv = ~lv; h1 = lv; if (b[i]) lv = ~lv; h2 = lv; end
        12, 13: begin
          if (!pv && !b[i]) lv = ~lv;
          h1 = lv;
          r = b[i] ? r + 1 : 0;
          if (b[i] && !(md == 13 && r % 2 == 0 && i + 1 < b.size() && !b[i+1])) lv = ~lv;
          h2 = lv;
        end
        default: tw = 1'h0;
      endcase
      if (tw) t = {h1, 1'h0, h2, 1'h0};
      e.push_back(t);
      pv = b[i];
      i++;
    end
    return e;
  endfunction
  // Far-end decoders: HDB3 strips V and B, modified Miller rebuilds suppressed ones
  function automatic bits_t dec(input int md, input sym_q_t s);
    bits_t o;
    logic  lp, t, nb, one;
    int    r;
    lp = 1'h0; r = 0;
    foreach (s[j]) begin
      if (md == 7) begin
        one = s[j][3] | s[j][2];
        o.push_back(one);
        // Same polarity as the last pulse marks a violation
        if (one && s[j][3] == lp) begin
          o[j] = 1'b0;
          if (j >= 3 && (s[j-3][3] | s[j-3][2]) && s[j-2] == 4'h0 && s[j-1] == 4'h0) o[j-3] = 1'b0;
        end
        if (one) lp = s[j][3];
      end else begin
        // Mid toggle is a one; a quiet bit after an odd run, then a quiet bit, is a held one
        t   = s[j][3] ^ s[j][1];
        nb  = (j + 1 < s.size()) && s[j+1][3] == s[j][1] && s[j+1][3] == s[j+1][1];
        one = t || (md == 13 && r % 2 == 1 && nb);
        o.push_back(one);
        r = one ? r + 1 : 0;
      end
    end
    return o;
  endfunction
  task automatic do_reset(input int md, input logic [15:0] rh);
    @(negedge clk);
    i_rstn = 1'h0; i_mode = 4'(md); i_rate_half = rh; i_valid = 1'h0;
    repeat (6) @(negedge clk);
    i_rstn = 1'h1;
  endtask
  // Offer one bit and hold it until an edge sees ready
  task automatic send(input bit b);
    int w;
    @(negedge clk);
    i_valid = 1'h1; i_data = b; w = 0;
    do begin @(posedge clk); w++; end while (o_ready !== 1'h1 && w < 1000);
    if (w >= 1000) begin err_total++; finish_test(); end
  endtask
  task automatic run_mode(input int md);
    bits_t  d;
    sym_q_t ex, rx;
    bits_t  bb;
    int     z, k, j, n;
    bit     hit;
    // Corner: odd and even mark counts before zero runs, long zero and one runs
    d = '{1, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 1, 1, 1, 1, 0};
    for (k = 0; k < 24; k++) d.push_back(1'($random(seed)));
    do_reset(md, 16'h0003);
    hot = 0; low_seen = 0;
    foreach (d[k]) send(d[k]);
    @(negedge clk) i_valid = 1'h0;
    chk_cnt(low_seen > 0, 1);
    repeat (16 * 6) @(posedge clk);
    if (md > 13) begin
      chk_cnt(hot, 0);
      return;
    end
    rx = line_rx_model_i.rx_q;
    n = d.size() + 4;
    z = 0;
    // Find how many idle zeros preceded the data on the line
    for (k = 1; k <= 8 && z == 0; k++) begin
      ex = enc(md, mk(k, d));
      hit = (rx.size() >= n + k);
      for (j = 0; hit && j < n + k; j++) if (rx[j] !== ex[j]) hit = 0;
      if (hit) z = k;
    end
    if (z == 0) z = 4;
    ex = enc(md, mk(z, d));
    chk_cnt(rx.size() >= n + z, 1);
    for (j = 0; j < n + z && j < rx.size(); j++)
      chk_sym(rx[j], ex[j]);
    bb = dec(md, rx);
    if (md == 7) foreach (d[k]) chk_bit(bb[z+k], d[k]);
    if (md == 13) foreach (d[k]) chk_bit(bb[z+k], d[k]);
  endtask
  initial begin
    int k;
    err_total = 0; tests_run = 0; seed = 47263;
    i_rstn = 1'h0; i_mode = 4'h0; i_auto_rate = 1'h0; i_rate_half = 16'h0003;
    i_valid = 1'h0; i_data = 1'h0;
    for (k = 0; k < 16; k++) run_mode(k);
    // Manual rate of zero falls back to the default 1 MHz bit
    do_reset(0, 16'h0000);
    k = 0;
    do begin @(posedge clk); k++; end while (o_bit_start !== 1'h1 && k < 500);
    k = 0;
    do begin @(posedge clk); k++; end while (o_bit_start !== 1'h1 && k < 500);
    chk_cnt(k, 124);
    // Auto rate: words every 10 cycles give a 5-cycle half-bit
    do_reset(0, 16'h0003);
    i_auto_rate = 1'h1;
    repeat (4) begin
      send(1'h1);
      @(negedge clk) i_valid = 1'h0;
      repeat (8) @(negedge clk);
    end
    k = 0;
    do begin @(posedge clk); k++; end while (o_bit_start !== 1'h1 && k < 500);
    k = 0;
    do begin @(posedge clk); k++; end while (o_bit_start !== 1'h1 && k < 500);
    chk_cnt(k, 10);
    i_auto_rate = 1'h0;
    finish_test();
  end
  // Hang guard, well above the expected few thousand cycles
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
endmodule // testbench
